/* File: hdl/pia_arbiter_map.svh */
// Register offsets, field positions, masks and source numbers of the interrupt arbiter
`ifndef PIA_ARBITER_MAP_SVH
`define PIA_ARBITER_MAP_SVH

// Word offsets on the peripheral bus
`define PIA_OFS_PRIO_0      5'h00
`define PIA_OFS_PRIO_1      5'h01
`define PIA_OFS_PRIO_2      5'h02
`define PIA_OFS_PRIO_3      5'h03
`define PIA_OFS_PRIO_4      5'h04
`define PIA_OFS_VBASE       5'h05
`define PIA_OFS_FMATCH_0    5'h06
`define PIA_OFS_FVLOW_0     5'h07
`define PIA_OFS_FVHIGH_0    5'h08
`define PIA_OFS_FMATCH_1    5'h09
`define PIA_OFS_FVLOW_1     5'h0A
`define PIA_OFS_FVHIGH_1    5'h0B
`define PIA_OFS_PEND_0      5'h0C
`define PIA_OFS_PEND_1      5'h0D
`define PIA_OFS_PEND_2      5'h0E
`define PIA_OFS_CTRL        5'h12

// Priority register that holds each level field
`define PIA_IDX_PRIO_0      3'h0
`define PIA_IDX_PRIO_1      3'h1

// Writable bits of the priority registers; reserved bits hold zero
`define PIA_MASK_PRIO_0     16'hC3FF
`define PIA_MASK_PRIO_1     16'hFCFF
`define PIA_MASK_PRIO_2     16'hF3FF
`define PIA_MASK_PRIO_3     16'hFFF0
`define PIA_MASK_PRIO_4     16'h00FF
`define PIA_RESET_VALUE     16'h0000

// Low bit of each two-bit level field
`define PIA_LSB_LOW_VOLT    4'hE
`define PIA_LSB_DBG_RX      4'h8
`define PIA_LSB_DBG_TX      4'h6
`define PIA_LSB_DBG_TRACE   4'h4
`define PIA_LSB_DBG_BKPT    4'h2
`define PIA_LSB_DBG_STEP    4'h0
`define PIA_LSB_PORT_B      4'hE
`define PIA_LSB_PORT_C      4'hC
`define PIA_LSB_PORT_D      4'hA
`define PIA_LSB_FL_EMPTY    4'h6
`define PIA_LSB_FL_DONE     4'h4
`define PIA_LSB_FL_ERR      4'h2
`define PIA_LSB_SYNTH       4'h0

// Source numbers, which are also the vector numbers
`define PIA_SRC_DBG_STEP    6'h01
`define PIA_SRC_DBG_BKPT    6'h02
`define PIA_SRC_DBG_TRACE   6'h03
`define PIA_SRC_DBG_TX      6'h04
`define PIA_SRC_DBG_RX      6'h05
`define PIA_SRC_LOW_VOLT    6'h06
`define PIA_SRC_SYNTH       6'h07
`define PIA_SRC_FL_ERR      6'h08
`define PIA_SRC_FL_DONE     6'h09
`define PIA_SRC_FL_EMPTY    6'h0A
`define PIA_SRC_PORT_D      6'h0B
`define PIA_SRC_PORT_C      6'h0C
`define PIA_SRC_PORT_B      6'h0D

// Level codes and the fast-service level
`define PIA_CODE_OFF        2'h0
`define PIA_LEVEL_FAST      2'h2

`endif

/* File: hdl/pia_pkg.sv */
// Types shared by the interrupt arbiter and its users
package pia_pkg;

  // One access on the peripheral register bus
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pia_bus_req_t;

  // Request presented to the processor core
  typedef struct packed {
    logic        req;
    logic        fast;
    logic [1:0]  level;
    logic [6:0]  vector;
    logic [20:0] addr;
  } pia_present_t;

  // Presentation state, Gray along idle -> show
  typedef enum logic [0:0] {
    PIA_ST_IDLE = 1'b0,
    PIA_ST_SHOW = 1'b1
  } pia_state_t;

endpackage

/* File: hdl/pia_interrupt_arbiter.sv */
// Priority interrupt arbiter: level registers, arbitration, vector presentation and wake request
`timescale 1ns/1ps
`include "pia_arbiter_map.svh"

// How it works
// - Arbitration runs from reset onward with no enabling step.
// - In wait or stop, a pending enabled request raises the wake output.
// - Only sources enabled before low-power entry may wake; software enables them first.
// - Sixteen registers decoded as a word offset from the block's base.
// - Priority 0-4 at 0-4, vector base at 5, fast channels at 6-8, 9-B.
// - Pending words at C, D, E and control at 12; other offsets reserved.
// - Priority 0 bits 15:14 set low-voltage level; 00 off, else levels 0-2.
// - Reserved priority bits read zero and ignore writes.
// - Priority 0 bits 9:8 set debug receive-full level; 00 off, else 1-3.
// - Priority 0 bits 7:6 set debug transmit-empty level; 00 off, else 1-3.
// - Priority 0 bits 5:4 set debug trace-buffer level; 00 off, else 1-3.
// - Priority 0 bits 3:2 set debug breakpoint level; 00 off, else 1-3.
// - Priority 0 bits 1:0 set debug step-counter level; 00 off, else 1-3.
// - Priority 1 bits 15:14 set port B pin level; 00 off, else 0-2.
// - Priority 1 bits 13:12 set port C pin level; 00 off, else 0-2.
// - Priority 1 bits 11:10 set port D pin level; 00 off, else 0-2.
// - Priority 1 bits 7:6 set flash buffers-empty level; 00 off, else 0-2.
// - Priority 1 bits 5:4 set flash command-done level; 00 off, else 0-2.
// - Priority 1 bits 3:2 set flash error level; 00 off, else 0-2.
// - All level fields reset to 00, every source disabled.
// - Priority 1 bits 1:0 set clock-synth lock level; 00 off, else 0-2.
// - Highest level wins; within a level the lowest source number wins.
// - Normal vector address is vector base joined with the vector number.
// - Level 2 winner matching a fast channel gets that channel's address.
module pia_interrupt_arbiter #(
  parameter int NSRC = 46,
  parameter int NFLD = 13
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire pia_pkg::pia_bus_req_t bus_i,
  output logic [15:0]                rdata_o,
  input  wire logic [NSRC-1:0]       irq_i,
  input  wire logic                  low_power_i,
  input  wire logic                  core_ack_i,
  output pia_pkg::pia_present_t      present_o,
  output logic                       wake_o
);

  // Field table: register index, low bit, source number, debug encoding
  // Only these thirteen sources own a field; the other lines never win
  localparam logic [2:0] FLD_REG [NFLD] = '{
    `PIA_IDX_PRIO_0, // Low voltage
    `PIA_IDX_PRIO_0, // Debug receive full
    `PIA_IDX_PRIO_0, // Debug transmit empty
    `PIA_IDX_PRIO_0, // Debug trace buffer
    `PIA_IDX_PRIO_0, // Debug breakpoint
    `PIA_IDX_PRIO_0, // Debug step counter
    `PIA_IDX_PRIO_1, // Port B pins
    `PIA_IDX_PRIO_1, // Port C pins
    `PIA_IDX_PRIO_1, // Port D pins
    `PIA_IDX_PRIO_1, // Flash buffers empty
    `PIA_IDX_PRIO_1, // Flash command done
    `PIA_IDX_PRIO_1, // Flash error
    `PIA_IDX_PRIO_1  // Clock synth lock
  };
  localparam logic [3:0] FLD_LSB [NFLD] = '{
    `PIA_LSB_LOW_VOLT,
    `PIA_LSB_DBG_RX,
    `PIA_LSB_DBG_TX,
    `PIA_LSB_DBG_TRACE,
    `PIA_LSB_DBG_BKPT,
    `PIA_LSB_DBG_STEP,
    `PIA_LSB_PORT_B,
    `PIA_LSB_PORT_C,
    `PIA_LSB_PORT_D,
    `PIA_LSB_FL_EMPTY,
    `PIA_LSB_FL_DONE,
    `PIA_LSB_FL_ERR,
    `PIA_LSB_SYNTH
  };
  localparam logic [5:0] FLD_SRC [NFLD] = '{
    `PIA_SRC_LOW_VOLT,
    `PIA_SRC_DBG_RX,
    `PIA_SRC_DBG_TX,
    `PIA_SRC_DBG_TRACE,
    `PIA_SRC_DBG_BKPT,
    `PIA_SRC_DBG_STEP,
    `PIA_SRC_PORT_B,
    `PIA_SRC_PORT_C,
    `PIA_SRC_PORT_D,
    `PIA_SRC_FL_EMPTY,
    `PIA_SRC_FL_DONE,
    `PIA_SRC_FL_ERR,
    `PIA_SRC_SYNTH
  };
  // Debug fields start at level 1, all others at level 0
  localparam logic FLD_DBG [NFLD] = '{
    1'b0, // Low voltage
    1'b1, // Debug receive full
    1'b1, // Debug transmit empty
    1'b1, // Debug trace buffer
    1'b1, // Debug breakpoint
    1'b1, // Debug step counter
    1'b0, // Port B pins
    1'b0, // Port C pins
    1'b0, // Port D pins
    1'b0, // Flash buffers empty
    1'b0, // Flash command done
    1'b0, // Flash error
    1'b0  // Clock synth lock
  };

  // Writable mask per priority register
  localparam logic [15:0] PRIO_MASK [5] = '{
    `PIA_MASK_PRIO_0,
    `PIA_MASK_PRIO_1,
    `PIA_MASK_PRIO_2,
    `PIA_MASK_PRIO_3,
    `PIA_MASK_PRIO_4
  };

  // Register storage
  logic [15:0]           prio_q [5];
  logic [15:0]           vbase_q;
  logic [15:0]           fmatch_q [2];
  logic [15:0]           fvlow_q [2];
  logic [15:0]           fvhigh_q [2];
  logic [15:0]           rdata_q;
  logic [15:0]           rdata_d;

  // Arbitration signals
  logic [1:0]            fcode [NFLD];
  logic [1:0]            flvl [NFLD];
  logic [NFLD-1:0]       fen;
  logic [NFLD-1:0]       factive;
  logic                  best_hit;
  logic [1:0]            best_lvl;
  logic [5:0]            best_src;
  logic                  fast0_hit;
  logic                  fast1_hit;
  logic [20:0]           addr_d;

  // Presentation and wake state
  pia_pkg::pia_state_t   state_q;
  pia_pkg::pia_present_t present_q;
  logic                  lp_q;
  logic [NFLD-1:0]       wake_mask_q;
  logic                  wake_q;
  logic [47:0]           pend_w;

  // Field decode: 00 disables; debug codes map to 1-3, the rest to 0-2
  // Non-debug codes shift down one, so 01 is level 0
  genvar k;
  generate
    for (k = 0; k < NFLD; k++)
    begin : g_field
      assign fcode[k]   = prio_q[FLD_REG[k]][FLD_LSB[k] +: 2];
      assign fen[k]     = (fcode[k] != `PIA_CODE_OFF);
      assign flvl[k]    = FLD_DBG[k] ? fcode[k] : fcode[k] - 2'h1;
      assign factive[k] = fen[k] & irq_i[FLD_SRC[k]];
    end
  endgenerate

  // Winner search; ties at a level go to the lower source number
  // Level compare first; the source number only breaks ties
  always_comb
  begin
    best_hit = 1'b0;
    best_lvl = 2'h0;
    best_src = 6'h00;
    for (int i = 0; i < NFLD; i++)
    begin
      if (factive[i] && (!best_hit || flvl[i] > best_lvl ||
          (flvl[i] == best_lvl && FLD_SRC[i] < best_src)))
      begin
        best_hit = 1'b1;
        best_lvl = flvl[i];
        best_src = FLD_SRC[i];
      end
    end
  end

  // Fast channels only apply at level 2; channel 0 beats channel 1
  // Both channels matching one vector is legal; the lower channel wins
  assign fast0_hit = best_lvl == `PIA_LEVEL_FAST && fmatch_q[0][6:0] == {1'b0, best_src};
  assign fast1_hit = best_lvl == `PIA_LEVEL_FAST && fmatch_q[1][6:0] == {1'b0, best_src};

  // Vector address source select
  // The six-bit source is padded to the seven-bit vector field
  always_comb
  begin
    if (fast0_hit)
    begin
      addr_d = {fvhigh_q[0][4:0], fvlow_q[0]};
    end
    else if (fast1_hit)
    begin
      addr_d = {fvhigh_q[1][4:0], fvlow_q[1]};
    end
    else
    begin
      addr_d = {vbase_q[13:0], 1'b0, best_src};
    end
  end

  // Priority registers; reserved bits never store
  // Masking on write keeps reserved bits zero in the flops themselves
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      for (int r = 0; r < 5; r++)
      begin
        prio_q[r] <= `PIA_RESET_VALUE;
      end
    end
    else if (bus_i.wr && bus_i.addr <= `PIA_OFS_PRIO_4)
    begin
      prio_q[bus_i.addr[2:0]] <= bus_i.wdata & PRIO_MASK[bus_i.addr[2:0]];
    end
  end

  // Vector base and fast channel registers
  // All sixteen bits stored; only the low bits reach the address
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      vbase_q <= `PIA_RESET_VALUE;
      for (int c = 0; c < 2; c++)
      begin
        fmatch_q[c] <= `PIA_RESET_VALUE;
        fvlow_q[c]  <= `PIA_RESET_VALUE;
        fvhigh_q[c] <= `PIA_RESET_VALUE;
      end
    end
    else if (bus_i.wr)
    begin
      case (bus_i.addr)
        `PIA_OFS_VBASE:    vbase_q     <= bus_i.wdata;
        `PIA_OFS_FMATCH_0: fmatch_q[0] <= bus_i.wdata;
        `PIA_OFS_FVLOW_0:  fvlow_q[0]  <= bus_i.wdata;
        `PIA_OFS_FVHIGH_0: fvhigh_q[0] <= bus_i.wdata;
        `PIA_OFS_FMATCH_1: fmatch_q[1] <= bus_i.wdata;
        `PIA_OFS_FVLOW_1:  fvlow_q[1]  <= bus_i.wdata;
        `PIA_OFS_FVHIGH_1: fvhigh_q[1] <= bus_i.wdata;
        default:           vbase_q     <= vbase_q;
      endcase
    end
  end

  // Pending view of every source line, bit n is source n
  // Live lines, not latched: a pending bit drops with its source
  assign pend_w = {{(48 - NSRC){1'b0}}, irq_i};

  // Read mux; reserved and unused offsets read zero
  // Pending and control offsets are read-only; writes there fall through
  always_comb
  begin
    case (bus_i.addr)
      `PIA_OFS_PRIO_0:   rdata_d = prio_q[0];
      `PIA_OFS_PRIO_1:   rdata_d = prio_q[1];
      `PIA_OFS_PRIO_2:   rdata_d = prio_q[2];
      `PIA_OFS_PRIO_3:   rdata_d = prio_q[3];
      `PIA_OFS_PRIO_4:   rdata_d = prio_q[4];
      `PIA_OFS_VBASE:    rdata_d = vbase_q;
      `PIA_OFS_FMATCH_0: rdata_d = fmatch_q[0];
      `PIA_OFS_FVLOW_0:  rdata_d = fvlow_q[0];
      `PIA_OFS_FVHIGH_0: rdata_d = fvhigh_q[0];
      `PIA_OFS_FMATCH_1: rdata_d = fmatch_q[1];
      `PIA_OFS_FVLOW_1:  rdata_d = fvlow_q[1];
      `PIA_OFS_FVHIGH_1: rdata_d = fvhigh_q[1];
      `PIA_OFS_PEND_0:   rdata_d = pend_w[15:0];
      `PIA_OFS_PEND_1:   rdata_d = pend_w[31:16];
      `PIA_OFS_PEND_2:   rdata_d = pend_w[47:32];
      `PIA_OFS_CTRL:     rdata_d = {wake_q, present_q.level, present_q.fast, 4'h0,
                                    present_q.req, present_q.vector};
      default:           rdata_d = 16'h0000;
    endcase
  end

  // Read data is registered so the bus sees a flop output
  // Holding between reads lets a slow master sample late
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= `PIA_RESET_VALUE;
    end
    else if (bus_i.rd)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Presentation: a shown request is frozen until the core acknowledges it
  // An ack costs one idle cycle, so a new winner settles before it shows
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_q   <= pia_pkg::PIA_ST_IDLE;
      present_q <= '0;
    end
    else
    begin
      case (state_q)
        pia_pkg::PIA_ST_IDLE:
        begin
          if (best_hit)
          begin
            state_q          <= pia_pkg::PIA_ST_SHOW;
            present_q.req    <= 1'b1;
            present_q.level  <= best_lvl;
            present_q.vector <= {1'b0, best_src};
            present_q.fast   <= fast0_hit | fast1_hit;
            present_q.addr   <= addr_d;
          end
        end
        pia_pkg::PIA_ST_SHOW:
        begin
          // Fields are not reloaded here, so writes cannot tear the vector
          if (core_ack_i)
          begin
            state_q       <= pia_pkg::PIA_ST_IDLE;
            present_q.req <= 1'b0;
          end
        end
        default:
        begin
          state_q   <= pia_pkg::PIA_ST_IDLE;
          present_q <= '0;
        end
      endcase
    end
  end

  // Enable snapshot taken on the cycle low-power mode is entered
  // Trade-off: a field enabled in low power still arbitrates but cannot wake
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      lp_q        <= 1'b0;
      wake_mask_q <= '0;
    end
    else
    begin
      lp_q <= low_power_i;
      if (low_power_i && !lp_q)
      begin
        wake_mask_q <= fen;
      end
    end
  end

  // Wake request; a field enabled after entry cannot wake the core
  // Drops the edge after low power ends, so no stale wake is left behind
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= low_power_i && lp_q && |(factive & wake_mask_q);
    end
  end

  // Outputs straight from flops
  // Every output is a flop, so the core sees no decode glitches
  assign rdata_o   = rdata_q;
  assign present_o = present_q;
  assign wake_o    = wake_q;

endmodule

/* File: test/pia_arbiter_props.sv */
// Checker: port properties of the interrupt arbiter
`timescale 1ns/1ps
`include "pia_arbiter_map.svh"
module pia_arbiter_props #(
  parameter int NSRC = 46,
  parameter int NFLD = 13
) (
  input wire logic                  clk_sys_i,
  input wire logic                  rst_n_i,
  input wire pia_pkg::pia_bus_req_t bus_i,
  input wire logic [15:0]           rdata_o,
  input wire logic [NSRC-1:0]       irq_i,
  input wire logic                  low_power_i,
  input wire logic                  core_ack_i,
  input wire pia_pkg::pia_present_t present_o,
  input wire logic                  wake_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Core handshake steps
  sequence s_shown;
    present_o.req && !core_ack_i;
  endsequence
  sequence s_taken;
    present_o.req && core_ack_i;
  endsequence

  // Outputs come out of reset cleared
  AST_RESET_CLEAR: assert property ($rose(rst_n_i) |-> present_o == '0 && !wake_o)
    else $error("outputs not clear after reset");
  // A shown request stays frozen until taken
  AST_REQ_HOLD: assert property (s_shown |=> present_o.req && $stable(present_o))
    else $error("presented request changed before ack");
  AST_ACK_DROP: assert property (s_taken |=> !present_o.req)
    else $error("request not dropped after ack");
  AST_RDATA_HOLD: assert property (!bus_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");
  AST_NORMAL_ADDR: assert property (present_o.req && !present_o.fast |-> present_o.addr[6:0] == present_o.vector)
    else $error("normal address does not carry vector");
  AST_FAST_LEVEL: assert property (present_o.req && present_o.fast |-> present_o.level == `PIA_LEVEL_FAST)
    else $error("fast address below level two");
  // Only debug sources can reach the top level
  AST_TOP_DEBUG: assert property (present_o.req && present_o.level == 2'h3 |-> present_o.vector inside {[7'h01:7'h05]})
    else $error("level three from a non debug source");
  AST_SRC_ACTIVE: assert property ($rose(present_o.req) |-> $past(irq_i) != '0)
    else $error("request shown with no source active");
  AST_WAKE_DROP: assert property (!low_power_i |=> !wake_o)
    else $error("wake held outside low power");
  AST_WAKE_CAUSE: assert property (wake_o |-> $past(irq_i) != '0)
    else $error("wake with no request");
endmodule

bind pia_interrupt_arbiter pia_arbiter_props #(.NSRC(NSRC), .NFLD(NFLD)) pia_arbiter_props_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .irq_i(irq_i),
  .low_power_i(low_power_i), .core_ack_i(core_ack_i), .present_o(present_o), .wake_o(wake_o));

/* File: test/pia_core_model.sv */
// Core model: takes presented requests after a set delay
`timescale 1ns/1ps
module pia_core_model (
  input  wire logic                  clk_sys_i,
  input  wire pia_pkg::pia_present_t present_i,
  input  wire logic                  ack_en_i,
  input  wire logic [3:0]            delay_i,
  output logic                       core_ack_o
);
  logic [3:0] wait_q = 4'h0;
  logic       ack_q  = 1'b0;

  // One-cycle ack; a stalled core lets the bench check the freeze
  always @(negedge clk_sys_i)
  begin
    if (!present_i.req || ack_q)
    begin
      wait_q <= 4'h0;
      ack_q  <= 1'b0;
    end
    else if (ack_en_i && wait_q >= delay_i)
      ack_q <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end

  // Single driver for the ack line
  assign core_ack_o = ack_q;
endmodule

/* File: test/priority_interrupt_arbiter_tb.sv */
// Self-checking bench of the interrupt arbiter
`timescale 1ns/1ps
`include "pia_arbiter_map.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module priority_interrupt_arbiter_tb;
  logic                  clk_sys_i;
  logic                  rst_n_i;
  pia_pkg::pia_bus_req_t bus;
  logic [15:0]           rdata;
  logic [45:0]           irq;
  logic                  low_power;
  logic                  core_ack;
  logic                  ack_en;
  logic                  wake;
  pia_pkg::pia_present_t present;
  pia_pkg::pia_present_t exp;
  logic [1:0]            lvl;
  int                    n_fail = 0;
  int                    samples_checked = 0;
  int                    i, s, c, lsb;
  logic [15:0]           msk [5] = '{`PIA_MASK_PRIO_0, `PIA_MASK_PRIO_1, `PIA_MASK_PRIO_2,
                                     `PIA_MASK_PRIO_3, `PIA_MASK_PRIO_4};
  logic [15:0]           rw [7] = '{16'h2ABC, 16'h0008, 16'h1234, 16'h001F, 16'h0009, 16'h5678, 16'h000A};

  pia_interrupt_arbiter pia_interrupt_arbiter_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .rdata_o(rdata), .irq_i(irq), .low_power_i(low_power), .core_ack_i(core_ack), .present_o(present),
    .wake_o(wake));
  pia_core_model pia_core_model_inst (.clk_sys_i(clk_sys_i), .present_i(present), .ack_en_i(ack_en),
    .delay_i(4'h2), .core_ack_o(core_ack));

  // Clock at 40 MHz
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Bus cycles, one strobe cycle each, driven at the falling edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    bus = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys_i);
    bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] ex);
    @(negedge clk_sys_i);
    bus = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk_sys_i);
    bus.rd = 1'b0;
    `CHK("rdata", ex, rdata)
  endtask
  // Bounded wait for the request line to reach a level
  task automatic wait_req(input logic lv);
    for (int k = 0; k < 40 && present.req !== lv; k++)
      @(negedge clk_sys_i);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well past the expected run of under five hundred cycles
  initial
  begin
    repeat (8000) @(posedge clk_sys_i);
    n_fail++;
    test_done();
  end

  // Test sequence
  initial
  begin
    bus = '0;
    irq = '0;
    low_power = 1'b0;
    ack_en = 1'b1;
    rst_n_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (i = 0; i < 5; i++)
    begin
      rd(5'(i), 16'h0000);
      wr(5'(i), 16'hFFFF);
      rd(5'(i), msk[i]);
    end
    for (i = 0; i < 7; i++)
    begin
      wr(5'(i + 5), rw[i]);
      rd(5'(i + 5), rw[i]);
    end
    wr(5'h10, 16'hFFFF);
    rd(5'h10, 16'h0000);
    irq = 46'h2A5A_C3C3_0F0F;
    rd(5'h0C, 16'h0F0F);
    rd(5'h0D, 16'hC3C3);
    rd(5'h0E, 16'h2A5A);
    irq = '0;
    wait_req(1'b0);
    $display("test registers done");
    // Every field, every nonzero code; sources 8 and 9 reach the fast channels at level two
    for (s = 1; s <= 13; s++)
      for (c = 1; c <= 3; c++)
      begin
        lsb = (s <= 5) ? 2 * (s - 1) : (s == 6) ? 14 : (s <= 10) ? 2 * (s - 7) : 2 * (s - 6);
        lvl = (s <= 5) ? 2'(c) : 2'(c - 1);
        wr((s <= 6) ? 5'h00 : 5'h01, 16'(c) << lsb);
        irq[s] = 1'b1;
        wait_req(1'b1);
        exp = '{1'b1, 1'b0, lvl, 7'(s), {rw[0][13:0], 7'(s)}};
        if (lvl == `PIA_LEVEL_FAST && (s == 8 || s == 9))
          exp = '{1'b1, 1'b1, lvl, 7'(s), (s == 8) ? {rw[3][4:0], rw[2]} : {rw[6][4:0], rw[5]}};
        `CHK("present", exp, present)
        irq[s] = 1'b0;
        wait_req(1'b0);
      end
    $display("test levels done");
    // Tie at level one, then a level change while the core stalls
    ack_en = 1'b0;
    wr(5'h01, 16'h2800);
    irq[12:11] = 2'b11;
    wait_req(1'b1);
    exp = '{1'b1, 1'b0, 2'h1, 7'd11, {rw[0][13:0], 7'd11}};
    `CHK("tie", exp, present)
    wr(5'h01, 16'h3800);
    repeat (3) @(negedge clk_sys_i);
    `CHK("frozen", exp, present)
    rd(5'h12, 16'h208B);
    ack_en = 1'b1;
    wait_req(1'b0);
    wait_req(1'b1);
    exp = '{1'b1, 1'b0, 2'h2, 7'd12, {rw[0][13:0], 7'd12}};
    `CHK("next", exp, present)
    irq = '0;
    wait_req(1'b0);
    $display("test order done");
    // Wake from a source enabled before entry, none from one enabled after
    wr(5'h01, 16'h4000);
    low_power = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    irq[13] = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    `CHK("wake", 1'b1, wake)
    low_power = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    `CHK("wake", 1'b0, wake)
    irq = '0;
    wr(5'h01, 16'h0000);
    low_power = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    wr(5'h01, 16'h4000);
    irq[13] = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    `CHK("wake", 1'b0, wake)
    irq = '0;
    low_power = 1'b0;
    // Second reset in mid-run
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(5'h01, 16'h0000);
    $display("test wake done");
    test_done();
  end
endmodule
